/* pkg/ep_flags_pkg.sv */
// Purpose: Shared constants and carrier types for the endpoint flag and frame stamp block.
// Assumes: One IN endpoint and one OUT endpoint, 32-bit APB register access.
// Notes:   Offsets are byte addresses of aligned words.
`default_nettype none
package ep_flags_pkg;

	// Register byte offsets.
	localparam logic [7:0] OFF_IN_FLAGS  = 8'h00; // IN endpoint event flags.
	localparam logic [7:0] OFF_IN_BUF    = 8'h04; // IN buffer size and initial PID.
	localparam logic [7:0] OFF_OUT_FLAGS = 8'h08; // OUT endpoint event flags.
	localparam logic [7:0] OFF_OUT_STAMP = 8'h0c; // OUT frame stamp and received PID.
	localparam logic [7:0] OFF_IN_MASK   = 8'h10; // Interrupt mask for IN flags.
	localparam logic [7:0] OFF_OUT_MASK  = 8'h14; // Interrupt mask for OUT flags.
	localparam logic [7:0] OFF_CTRL      = 8'h18; // Mode control.

	// Field positions inside the flag registers.
	localparam int BIT_BUF_UNAVAIL = 7; // Buffer unavailable flag.
	localparam int BIT_INTOK   = 6; // IN token flag.
	localparam int BIT_OUT_LO  = 4; // Low bit of the OUT data type field.
	localparam int BIT_PID_LO  = 16; // Low bit of the PID fields.
	localparam int BIT_DMA     = 0; // Control: DMA mode when set.
	localparam int BIT_HS      = 1; // Control: high-speed operation when set.

	// OUT data type encodings.
	localparam logic [1:0] OUT_NONE  = 2'h0; // Nothing received.
	localparam logic [1:0] OUT_DATA  = 2'h1; // Ordinary data received.
	localparam logic [1:0] OUT_SETUP = 2'h3; // Eight bytes of SETUP data received.

	// Descriptor status encodings seen by the DMA.
	localparam logic [1:0] DESC_HOST_READY = 2'h0; // Ready for the DMA.
	localparam logic [1:0] DESC_HOST_BUSY  = 2'h1; // Still held by software.
	localparam logic [1:0] DESC_DMA_BUSY   = 2'h2; // Being worked on.
	localparam logic [1:0] DESC_DMA_DONE   = 2'h3; // Already completed.

	// Data PID codes on the transmit side.
	localparam logic [1:0] PID_DATA0 = 2'h0; // DATA0.
	localparam logic [1:0] PID_DATA1 = 2'h1; // DATA1.
	localparam logic [1:0] PID_DATA2 = 2'h2; // DATA2.

	// Reset values.
	localparam logic [31:0] RST_ZERO = 32'h0000_0000; // Every register resets to zero.

	// Events from the link and DMA side, all one-cycle pulses with their data.
	typedef struct packed {
		logic       desc_access;  // DMA touched a descriptor this cycle.
		logic [1:0] desc_status;  // Status word of that descriptor.
		logic       token;        // IN token received.
	} in_evt_t;

	typedef struct packed {
		logic        desc_access; // DMA touched a descriptor this cycle.
		logic [1:0]  desc_status; // Status word of that descriptor.
		logic        pkt;         // OUT packet received.
		logic        setup;       // The packet was SETUP data.
		logic [1:0]  pid;         // Data PID of the packet in the receive FIFO.
		logic [10:0] frame;       // Millisecond frame number.
		logic [2:0]  uframe;      // Microframe number.
	} out_evt_t;

endpackage
`default_nettype wire

/* src/usb_endpoint_status_frame.sv */
// Purpose: Endpoint event flags, IN buffer size and OUT frame stamp behind an APB slave.
// Assumes: Link and DMA events are synchronous one-cycle pulses on clk.
// Notes:   APB answers in the first access cycle; level interrupt from masked flags.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module usb_endpoint_status_frame #(
	parameter int BUF_W = 16 // Width of the transmit word allotment.
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire ep_flags_pkg::in_evt_t    in_evt,
	input  wire ep_flags_pkg::out_evt_t   out_evt,
	output logic      [1:0]               iso_tx_initial_pid,
	output logic                          iso_tx_pid_valid,
	output logic      [BUF_W-1:0]         tx_fifo_word_allotment,
	output logic                          irq
);

	// Refuse widths that do not fit the 16-bit field.
	if (BUF_W < 1 || BUF_W > 16) begin : g_chk
		$error("BUF_W must lie between 1 and 16");
	end

	// Clear a flag group: ones written clear, new hardware sets win.
	function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] clr,
		input logic [7:0] set);
		w1c = (cur & ~clr) | set;
	endfunction

	// True when a descriptor was not ready for the DMA.
	function automatic logic not_ready(input logic [1:0] st);
		not_ready = (st == ep_flags_pkg::DESC_HOST_BUSY) || (st == ep_flags_pkg::DESC_DMA_DONE);
	endfunction

	// Flag registers hold bits 7:0 of the flag word; the rest reads zero.
	logic [7:0]       in_flags_r;     // IN flags.
	logic [7:0]       in_flags_nxt;   // Next IN flags.
	logic [7:0]       out_flags_r;    // OUT flags.
	logic [7:0]       out_flags_nxt;  // Next OUT flags.
	logic [7:0]       in_mask_r;      // IN interrupt mask.
	logic [7:0]       out_mask_r;     // OUT interrupt mask.
	logic [1:0]       ctrl_r;         // Mode control bits.
	logic [1:0]       tx_pid_field_r; // Programmed initial PID field.
	logic [BUF_W-1:0] buf_size_r;     // Programmed buffer size.
	logic [1:0]       rx_pid_r;       // Last received PID.
	logic [15:0]      stamp_r;        // Frame stamp of the last OUT packet.
	logic [15:0]      stamp_nxt;      // Stamp formed from the current packet.
	logic [1:0]       tx_pid_code;    // Mapped initial PID.

	// Bus decode wires.
	logic setup_ph;  // Setup phase of a transfer.
	logic acc_done;  // Access phase completing this edge.
	logic wr_en;     // Write takes effect this edge.
	logic hit;       // Address is mapped.
	logic [31:0] rd_word; // Read data for the addressed register.
	logic [7:0] in_set;   // Hardware sets for IN flags.
	logic [7:0] out_set;  // Hardware sets for OUT flags.
	logic [7:0] in_clr;   // Software clears for IN flags.
	logic [7:0] out_clr;  // Software clears for OUT flags.
	logic [7:0] out_w1c;  // OUT flags after clears and sets.
	logic dma_mode;       // DMA mode selected.
	logic hs_mode;        // High-speed operation selected.

	assign dma_mode = ctrl_r[ep_flags_pkg::BIT_DMA];
	assign hs_mode  = ctrl_r[ep_flags_pkg::BIT_HS];
	assign setup_ph = psel && !penable;
	assign acc_done = psel && penable && pready;
	assign wr_en    = acc_done && pwrite && !pslverr;

	// Address decode for the seven mapped words.
	assign hit = (paddr == ep_flags_pkg::OFF_IN_FLAGS) || (paddr == ep_flags_pkg::OFF_IN_BUF) ||
		(paddr == ep_flags_pkg::OFF_OUT_FLAGS) || (paddr == ep_flags_pkg::OFF_OUT_STAMP) ||
		(paddr == ep_flags_pkg::OFF_IN_MASK) || (paddr == ep_flags_pkg::OFF_OUT_MASK) ||
		(paddr == ep_flags_pkg::OFF_CTRL);

	// Hardware set terms for the IN flags.
	assign in_set[ep_flags_pkg::BIT_BUF_UNAVAIL] =
		in_evt.desc_access && not_ready(in_evt.desc_status);
	assign in_set[ep_flags_pkg::BIT_INTOK] = in_evt.token;
	assign in_set[5:0] = 6'h00;

	// Hardware set terms for the OUT flags; the IN token bit stays reserved here.
	assign out_set[ep_flags_pkg::BIT_BUF_UNAVAIL] =
		out_evt.desc_access && not_ready(out_evt.desc_status);
	assign out_set[6] = 1'b0;
	assign out_set[5:4] = !out_evt.pkt ? ep_flags_pkg::OUT_NONE :
		(out_evt.setup ? ep_flags_pkg::OUT_SETUP : ep_flags_pkg::OUT_DATA);
	assign out_set[3:0] = 4'h0;

	// Software clear terms: a one written to a flag bit clears it.
	assign in_clr  = (wr_en && paddr == ep_flags_pkg::OFF_IN_FLAGS) ? pwdata[7:0] : 8'h00;
	assign out_clr = (wr_en && paddr == ep_flags_pkg::OFF_OUT_FLAGS) ? pwdata[7:0] : 8'h00;

	// Next flag values; the OUT field takes the new type whole when a packet lands.
	assign in_flags_nxt = w1c(in_flags_r, in_clr, in_set) & 8'hc0;
	assign out_w1c = w1c(out_flags_r, out_clr, out_set);
	assign out_flags_nxt[7:6] = out_w1c[7:6] & 2'h2;
	assign out_flags_nxt[5:4] = out_evt.pkt ? out_set[5:4] :
		(out_flags_r[5:4] & ~out_clr[5:4]);
	assign out_flags_nxt[3:0] = 4'h0;

	// Frame stamp layout depends on the bus speed.
	assign stamp_nxt = hs_mode ? {2'h0, out_evt.frame, out_evt.uframe} :
		{5'h00, out_evt.frame};

	// Initial PID: both low codes send DATA0.
	assign tx_pid_code = (tx_pid_field_r == 2'h3) ? ep_flags_pkg::PID_DATA2 :
		(tx_pid_field_r == 2'h2) ? ep_flags_pkg::PID_DATA1 : ep_flags_pkg::PID_DATA0;

	// Read data mux.
	always_comb begin
		rd_word = ep_flags_pkg::RST_ZERO;
		case (paddr)
			ep_flags_pkg::OFF_IN_FLAGS: rd_word = {24'h0, in_flags_r};
			ep_flags_pkg::OFF_IN_BUF: begin
				rd_word[17:16] = tx_pid_field_r;
				rd_word[BUF_W-1:0] = buf_size_r;
			end
			ep_flags_pkg::OFF_OUT_FLAGS: rd_word = {24'h0, out_flags_r};
			ep_flags_pkg::OFF_OUT_STAMP: rd_word = {14'h0, rx_pid_r, stamp_r};
			ep_flags_pkg::OFF_IN_MASK: rd_word = {24'h0, in_mask_r};
			ep_flags_pkg::OFF_OUT_MASK: rd_word = {24'h0, out_mask_r};
			ep_flags_pkg::OFF_CTRL: rd_word = {30'h0, ctrl_r};
			default: rd_word = ep_flags_pkg::RST_ZERO;
		endcase
	end

	// APB handshake: ready in the first access cycle, error on unmapped words.
	always_ff @(posedge clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= ep_flags_pkg::RST_ZERO;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph && !hit;
			prdata  <= setup_ph ? rd_word : ep_flags_pkg::RST_ZERO;
		end
	end

	// Event flags; software clears, hardware sets win.
	always_ff @(posedge clk) begin
		if (rst) begin
			in_flags_r  <= 8'h00;
			out_flags_r <= 8'h00;
		end else begin
			in_flags_r  <= in_flags_nxt;
			out_flags_r <= out_flags_nxt;
		end
	end

	// Software-written configuration.
	always_ff @(posedge clk) begin
		if (rst) begin
			in_mask_r      <= 8'h00;
			out_mask_r     <= 8'h00;
			ctrl_r         <= 2'h0;
			tx_pid_field_r <= 2'h0;
			buf_size_r     <= '0;
		end else if (wr_en) begin
			if (paddr == ep_flags_pkg::OFF_IN_MASK) begin
				in_mask_r <= pwdata[7:0] & 8'hc0;
			end
			if (paddr == ep_flags_pkg::OFF_OUT_MASK) begin
				out_mask_r <= pwdata[7:0] & 8'hb0;
			end
			if (paddr == ep_flags_pkg::OFF_CTRL) begin
				ctrl_r <= pwdata[1:0];
			end
			if (paddr == ep_flags_pkg::OFF_IN_BUF) begin
				tx_pid_field_r <= pwdata[17:16];
				buf_size_r     <= pwdata[BUF_W-1:0];
			end
		end
	end

	// Received PID and frame stamp; the PID is only tracked without DMA.
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_pid_r <= 2'h0;
			stamp_r  <= 16'h0000;
		end else if (out_evt.pkt) begin
			stamp_r <= stamp_nxt;
			if (!dma_mode) begin
				rx_pid_r <= out_evt.pid;
			end
		end
	end

	// Outputs toward the transmit path and the interrupt line.
	always_ff @(posedge clk) begin
		if (rst) begin
			iso_tx_initial_pid     <= ep_flags_pkg::PID_DATA0;
			iso_tx_pid_valid       <= 1'b0;
			tx_fifo_word_allotment <= '0;
			irq                    <= 1'b0;
		end else begin
			iso_tx_initial_pid     <= tx_pid_code;
			iso_tx_pid_valid       <= !dma_mode;
			tx_fifo_word_allotment <= buf_size_r;
			irq <= |(in_flags_nxt & in_mask_r) || |(out_flags_nxt & out_mask_r);
		end
	end

	// Sequences for the assertions below.
	sequence s_token_seen;
		in_evt.token;
	endsequence

	sequence s_setup_pkt;
		out_evt.pkt && out_evt.setup;
	endsequence

	a_unavail_out_set: assert property (@(posedge clk) disable iff (rst)
		out_evt.desc_access && out_evt.desc_status == ep_flags_pkg::DESC_DMA_DONE
		|=> out_flags_r[ep_flags_pkg::BIT_BUF_UNAVAIL])
		else $error("buffer unavailable flag not set");

	a_token_flag: assert property (@(posedge clk) disable iff (rst)
		s_token_seen |=> in_flags_r[ep_flags_pkg::BIT_INTOK] && !out_flags_r[6])
		else $error("IN token flag wrong");

	a_setup_type: assert property (@(posedge clk) disable iff (rst)
		s_setup_pkt |=> out_flags_r[5:4] == ep_flags_pkg::OUT_SETUP)
		else $error("SETUP type not recorded");

	a_data_type: assert property (@(posedge clk) disable iff (rst)
		out_evt.pkt && !out_evt.setup |=> out_flags_r[5:4] == ep_flags_pkg::OUT_DATA)
		else $error("data type not recorded");

	a_hs_stamp: assert property (@(posedge clk) disable iff (rst)
		out_evt.pkt && hs_mode |=> stamp_r[13:3] == $past(out_evt.frame)
		&& stamp_r[2:0] == $past(out_evt.uframe) && stamp_r[15:14] == 2'h0)
		else $error("high speed stamp wrong");

	a_fs_stamp: assert property (@(posedge clk) disable iff (rst)
		out_evt.pkt && !hs_mode |=> stamp_r == {5'h00, $past(out_evt.frame)})
		else $error("full speed stamp wrong");

	a_pid_map: assert property (@(posedge clk) disable iff (rst)
		tx_pid_field_r == 2'h1 ##1 tx_pid_field_r == 2'h1
		|-> iso_tx_initial_pid == ep_flags_pkg::PID_DATA0)
		else $error("initial PID mapping wrong");

	a_dma_hold: assert property (@(posedge clk) disable iff (rst)
		out_evt.pkt && dma_mode |=> $stable(rx_pid_r))
		else $error("PID changed in DMA mode");

	a_set_wins: assert property (@(posedge clk) disable iff (rst)
		s_token_seen ##0 in_clr[ep_flags_pkg::BIT_INTOK]
		|=> in_flags_r[ep_flags_pkg::BIT_INTOK])
		else $error("clear beat a set");

	a_clear_one: assert property (@(posedge clk) disable iff (rst)
		in_clr[ep_flags_pkg::BIT_BUF_UNAVAIL] && !in_set[ep_flags_pkg::BIT_BUF_UNAVAIL]
		|=> !in_flags_r[ep_flags_pkg::BIT_BUF_UNAVAIL])
		else $error("write one did not clear");

	a_buf_out: assert property (@(posedge clk) disable iff (rst)
		wr_en && paddr == ep_flags_pkg::OFF_IN_BUF
		|=> ##1 tx_fifo_word_allotment == $past(pwdata[BUF_W-1:0], 2))
		else $error("buffer size not forwarded");

	// Setup phase of an APB transfer, the first step of every access.
	sequence s_apb_setup;
		psel && !penable;
	endsequence

	// A descriptor held by software or already done raises the IN flag.
	a_unavail_in_set: assert property (@(posedge clk) disable iff (rst)
		in_evt.desc_access && (in_evt.desc_status == ep_flags_pkg::DESC_HOST_BUSY ||
		in_evt.desc_status == ep_flags_pkg::DESC_DMA_DONE)
		|=> in_flags_r[ep_flags_pkg::BIT_BUF_UNAVAIL])
		else $error("IN buffer unavailable flag not set");

	// A ready or busy descriptor must not raise a clear flag.
	a_unavail_refused: assert property (@(posedge clk) disable iff (rst)
		in_evt.desc_access && (in_evt.desc_status == ep_flags_pkg::DESC_HOST_READY ||
		in_evt.desc_status == ep_flags_pkg::DESC_DMA_BUSY)
		&& !in_flags_r[ep_flags_pkg::BIT_BUF_UNAVAIL]
		|=> !in_flags_r[ep_flags_pkg::BIT_BUF_UNAVAIL])
		else $error("buffer unavailable flag set by a ready descriptor");

	// A programmed code of two sends DATA1 once the output has followed.
	a_pid_data1: assert property (@(posedge clk) disable iff (rst)
		tx_pid_field_r == 2'h2 ##1 tx_pid_field_r == 2'h2
		|-> iso_tx_initial_pid == ep_flags_pkg::PID_DATA1)
		else $error("initial PID not DATA1");

	// A programmed code of three sends DATA2 once the output has followed.
	a_pid_data2: assert property (@(posedge clk) disable iff (rst)
		tx_pid_field_r == 2'h3 ##1 tx_pid_field_r == 2'h3
		|-> iso_tx_initial_pid == ep_flags_pkg::PID_DATA2)
		else $error("initial PID not DATA2");

	// Without DMA the received PID follows every packet.
	a_rx_pid_cpu: assert property (@(posedge clk) disable iff (rst)
		out_evt.pkt && !dma_mode |=> rx_pid_r == $past(out_evt.pid))
		else $error("received PID not recorded");

	// In DMA mode the transmit PID is flagged as not in use.
	a_pid_valid: assert property (@(posedge clk) disable iff (rst)
		dma_mode ##1 dma_mode |-> !iso_tx_pid_valid)
		else $error("PID marked valid in DMA mode");

	// The frame stamp only moves when a packet lands.
	a_stamp_hold: assert property (@(posedge clk) disable iff (rst)
		!out_evt.pkt |=> $stable(stamp_r))
		else $error("frame stamp moved without a packet");

	// The interrupt is high exactly while a flag is set under its mask as it stood one cycle earlier.
	a_irq_level: assert property (@(posedge clk) disable iff (rst)
		irq == ((|(in_flags_r & $past(in_mask_r))) || (|(out_flags_r & $past(out_mask_r)))))
		else $error("interrupt level wrong");

	// Every setup phase is answered in the next cycle.
	a_apb_answer: assert property (@(posedge clk) disable iff (rst)
		s_apb_setup |=> pready)
		else $error("no ready in the access cycle");

	// Ready stands for a single cycle.
	a_apb_pulse: assert property (@(posedge clk) disable iff (rst)
		pready |=> !pready)
		else $error("ready held too long");

	// Addresses beyond the map are refused with zero read data.
	a_unmapped_err: assert property (@(posedge clk) disable iff (rst)
		s_apb_setup && paddr > ep_flags_pkg::OFF_CTRL
		|=> pslverr && prdata == ep_flags_pkg::RST_ZERO)
		else $error("unmapped address not refused");

	// Reset clears the buffer size and both PID fields.
	a_reset_zero: assert property (@(posedge clk)
		rst |=> buf_size_r == '0 && tx_pid_field_r == 2'h0 && rx_pid_r == 2'h0)
		else $error("fields not zero after reset");

endmodule // usb_endpoint_status_frame
`default_nettype wire

/* dv/usb_host_model.sv */
// Purpose: Far-side model that raises link and DMA events toward the block.
// Assumes: Events are one-cycle pulses launched just after a rising edge.
// Notes:   Data lines show the inverse of their last value once a pulse ends.
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
	input  wire logic                  clk,
	output var  ep_flags_pkg::in_evt_t  in_evt,
	output var  ep_flags_pkg::out_evt_t out_evt
);
	// Both event buses start idle.
	initial begin
		in_evt  = '0;
		out_evt = '0;
	end

	// Pulse an IN token and/or a descriptor touch for one cycle.
	task automatic in_ev(input logic tok, input logic acc, input logic [1:0] st);
		in_evt <= '{acc, st, tok};
		@(posedge clk);
		in_evt <= '{1'b0, ~st, 1'b0};
		@(posedge clk);
	endtask

	// Pulse an OUT packet and/or a descriptor touch with its stamp data.
	task automatic out_ev(input logic pk, input logic su, input logic [1:0] pid,
			input logic [10:0] fr, input logic [2:0] uf, input logic acc,
			input logic [1:0] st);
		out_evt <= '{acc, st, pk, su, pid, fr, uf};
		@(posedge clk);
		out_evt <= '{1'b0, ~st, 1'b0, ~su, ~pid, ~fr, ~uf};
		@(posedge clk);
	endtask
endmodule // usb_host_model
`default_nettype wire

/* dv/tb_top.sv */
// Purpose: Self-checking bench for the endpoint flag and frame stamp block.
// Assumes: APB answers within a few cycles; one clock at 10 MHz.
// Notes:   Expected values are built from field layouts, never from outputs.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, pvld;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [1:0]  ipid;
	logic [15:0] allot;
	logic        e;
	int          mismatches, n_tests;
	ep_flags_pkg::in_evt_t  in_evt;
	ep_flags_pkg::out_evt_t out_evt;

	// The DUT and the far-side event source.
	usb_endpoint_status_frame u_usb_endpoint_status_frame (.clk(clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.in_evt(in_evt), .out_evt(out_evt), .iso_tx_initial_pid(ipid),
		.iso_tx_pid_valid(pvld), .tx_fifo_word_allotment(allot), .irq(irq));
	usb_host_model u_usb_host_model (.clk(clk), .in_evt(in_evt), .out_evt(out_evt));

	// A 100 ns clock.
	initial clk = 1'b0;
	always #50 clk = ~clk;

	// Verdict and end of run.
	task automatic results();
		if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// Count a comparison and report a difference.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer: setup, access until pready, then release.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk);
		end
		if (n == 20) mismatches++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// Read a register and compare it.
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	// Watchdog cut-off far beyond the expected run.
	initial begin
		#1_000_000;
		mismatches++;
		results();
	end

	// Main sequence.
	initial begin
		mismatches = 0;
		n_tests = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int a = 0; a < 28; a += 4) rd(8'(a), 32'h0);
		rd(8'h1c, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, ep_flags_pkg::OFF_IN_MASK, 32'hc0);
		apb(1'b1, ep_flags_pkg::OFF_OUT_MASK, 32'hb0);
		// An IN token sets its flag and the interrupt.
		u_usb_host_model.in_ev(1'b1, 1'b0, 2'h0);
		chk({31'h0, irq}, 32'h1);
		rd(ep_flags_pkg::OFF_IN_FLAGS, 32'h40);
		apb(1'b1, ep_flags_pkg::OFF_IN_FLAGS, 32'h0);
		rd(ep_flags_pkg::OFF_IN_FLAGS, 32'h40);
		apb(1'b1, ep_flags_pkg::OFF_IN_FLAGS, 32'h40);
		rd(ep_flags_pkg::OFF_IN_FLAGS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// Only host-busy and DMA-done descriptors raise the flag.
		for (int s = 0; s < 4; s++) begin
			u_usb_host_model.in_ev(1'b0, 1'b1, 2'(s));
			rd(ep_flags_pkg::OFF_IN_FLAGS, (s == 1 || s == 3) ? 32'h80 : 32'h0);
			apb(1'b1, ep_flags_pkg::OFF_IN_FLAGS, 32'h80);
		end
		// A masked flag keeps the interrupt low.
		apb(1'b1, ep_flags_pkg::OFF_IN_MASK, 32'h0);
		u_usb_host_model.in_ev(1'b1, 1'b0, 2'h0);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, ep_flags_pkg::OFF_IN_FLAGS, 32'h40);
		// A token landing on the clearing edge keeps the flag set.
		fork
			apb(1'b1, ep_flags_pkg::OFF_IN_FLAGS, 32'h40);
			begin
				@(posedge clk);
				u_usb_host_model.in_ev(1'b1, 1'b0, 2'h0);
			end
		join
		rd(ep_flags_pkg::OFF_IN_FLAGS, 32'h40);
		apb(1'b1, ep_flags_pkg::OFF_IN_FLAGS, 32'h40);
		// Full speed, CPU mode: data packet, then SETUP overwrites the type.
		apb(1'b1, ep_flags_pkg::OFF_CTRL, 32'h0);
		u_usb_host_model.out_ev(1'b1, 1'b0, 2'h2, 11'h5a5, 3'h6, 1'b0, 2'h0);
		rd(ep_flags_pkg::OFF_OUT_FLAGS, 32'h10);
		rd(ep_flags_pkg::OFF_OUT_STAMP, {14'h0, 2'h2, 5'h0, 11'h5a5});
		chk({31'h0, irq}, 32'h1);
		u_usb_host_model.out_ev(1'b1, 1'b1, 2'h1, 11'h033, 3'h1, 1'b0, 2'h0);
		rd(ep_flags_pkg::OFF_OUT_FLAGS, 32'h30);
		// High speed splits frame and microframe.
		apb(1'b1, ep_flags_pkg::OFF_CTRL, 32'h2);
		u_usb_host_model.out_ev(1'b1, 1'b0, 2'h3, 11'h7ff, 3'h5, 1'b0, 2'h0);
		rd(ep_flags_pkg::OFF_OUT_STAMP, {14'h0, 2'h3, 2'h0, 11'h7ff, 3'h5});
		// DMA mode freezes the received PID but not the stamp.
		apb(1'b1, ep_flags_pkg::OFF_CTRL, 32'h3);
		u_usb_host_model.out_ev(1'b1, 1'b0, 2'h1, 11'h101, 3'h2, 1'b1, 2'h3);
		rd(ep_flags_pkg::OFF_OUT_STAMP, {14'h0, 2'h3, 2'h0, 11'h101, 3'h2});
		rd(ep_flags_pkg::OFF_OUT_FLAGS, 32'h90);
		chk({31'h0, pvld}, 32'h0);
		apb(1'b1, ep_flags_pkg::OFF_OUT_FLAGS, 32'hb0);
		rd(ep_flags_pkg::OFF_OUT_FLAGS, 32'h0);
		// Buffer size and initial PID mapping; upper bits are dropped.
		apb(1'b1, ep_flags_pkg::OFF_CTRL, 32'h0);
		for (int v = 0; v < 4; v++) begin
			apb(1'b1, ep_flags_pkg::OFF_IN_BUF, {14'h3fff, 2'(v), 16'h0123 + 16'(v)});
			// The output registers follow the fields one edge after the write.
			@(posedge clk);
			chk({30'h0, ipid}, (v < 2) ? 32'h0 : 32'(v - 1));
			chk({16'h0, allot}, 32'h0123 + 32'(v));
			chk({31'h0, pvld}, 32'h1);
			rd(ep_flags_pkg::OFF_IN_BUF, {14'h0, 2'(v), 16'h0123 + 16'(v)});
		end
		results();
	end
endmodule // tb_top
`default_nettype wire
